//--- shared/tcc_pkg.sv
// constants, types and behaviour notes for the timer clock/compare/capture
// Notes on behaviour
// [RULE_01] source code 0 fast, 1 slow, 3 event
// [RULE_02] event pin never driven as port output
// [RULE_03] internal divide by two to the code
// [RULE_04] gate enable passes count clock when set
// [RULE_05] stop counter before changing clock settings
// [RULE_06] per-register mode bit: comparator or capture
// [RULE_07] count equals A: event, flag, irq
// [RULE_08] count equals B: event, flag, clear counter
// [RULE_09] compare fires after value plus one clocks
// [RULE_10] PWM needs both registers in comparator mode
// [RULE_11] buffer mode matches shadows, reload on B
// [RULE_12] space compare writes one count clock apart
// [RULE_13] edge selector: none, rise, fall, both
// [RULE_14] selected edge captures count, sets flag
// [RULE_15] capture while flag set sets overwrite
// [RULE_16] software clears capture flag after reading
// [RULE_17] trigger phases longer than source period
// [RULE_18] comparator mode ignores capture edges
// [RULE_19] capture mode produces no compare events
// [RULE_20] software reads capture value twice
// [RULE_21] 16-bit up counter, software clearable
// [RULE_22] all causes share one interrupt line
// [RULE_23] event clock synchronised, one count per rise
package tcc_pkg;

  localparam int CNT_W = 16;
  localparam int PRE_W = 15;

  localparam logic [1:0] SRC_FAST  = 2'h0;
  localparam logic [1:0] SRC_SLOW  = 2'h1;
  localparam logic [1:0] SRC_EVENT = 2'h3;

  localparam logic [3:0] DIV_FAST_MAX = 4'hE;
  localparam logic [3:0] DIV_SLOW_MAX = 4'h8;

  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  localparam int FLG_CMP_A = 0;
  localparam int FLG_CMP_B = 1;
  localparam int FLG_CAP_A = 2;
  localparam int FLG_CAP_B = 3;
  localparam int FLG_OVW_A = 4;
  localparam int FLG_OVW_B = 5;
  localparam int FLG_W     = 6;

  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [FLG_W-1:0] FLG_RESET = 6'h00;

  typedef struct packed {
    logic [1:0] clock_source_select;
    logic [3:0] clock_divide_select;
    logic       count_clock_gate_enable;
    logic       run;
    logic       reg_a_mode_select;
    logic       reg_b_mode_select;
    logic       compare_buffer_enable;
    logic [1:0] capture_a_edge_select;
    logic [1:0] capture_b_edge_select;
  } tcc_cfg_t;

  typedef struct packed {
    logic             we;
    logic [CNT_W-1:0] data;
  } tcc_wr_t;

endpackage

//--- design/tcc_timer.sv
// count clock controller and compare/capture pair of a 16-bit timer
`timescale 1ns/10ps

// ==========================================================
// two-flop synchroniser
module tcc_sync #(parameter int W = 1) (
  input  wire logic         ref_clk, // timer clock
  input  wire logic         reset,   // sync reset
  input  wire logic [W-1:0] d,       // asynchronous inputs
  output logic      [W-1:0] q        // synchronised
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ==========================================================
module tcc_timer (
  input  wire logic                     ref_clk,        // 20 MHz clock
  input  wire logic                     reset,          // sync, high
  input  wire tcc_pkg::tcc_cfg_t        cfg,            // control bits
  input  wire logic                     counter_clear,  // clear pulse
  input  wire tcc_pkg::tcc_wr_t         wr_a,           // compare A write
  input  wire tcc_pkg::tcc_wr_t         wr_b,           // compare B write
  input  wire logic [5:0]               flag_clear,     // write-1 clear
  input  wire logic [5:0]               irq_enable,     // cause enables
  input  wire logic                     fast_oscillator,      // pin
  input  wire logic                     slow_oscillator,      // pin
  input  wire logic                     event_clock_in,       // pin
  input  wire logic                     capture_a_trigger_in, // pin
  input  wire logic                     capture_b_trigger_in, // pin
  output logic [tcc_pkg::CNT_W-1:0]     count_value,    // counter
  output logic [tcc_pkg::CNT_W-1:0]     reg_a_value,    // cmp/cap A
  output logic [tcc_pkg::CNT_W-1:0]     reg_b_value,    // cmp/cap B
  output logic [5:0]                    flags,          // sticky causes
  output logic                          compare_a_event, // pulse
  output logic                          compare_b_event, // pulse
  output logic                          irq_req         // shared irq
);
  import tcc_pkg::*;

  // ==========================================================
  // input synchronisation and edge detection
  logic [4:0] pin_sync;
  logic [4:0] pin_prev_reg;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  tcc_sync #(.W(5)) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .d       ({capture_b_trigger_in, capture_a_trigger_in,
               event_clock_in, slow_oscillator, fast_oscillator}),
    .q       (pin_sync)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) pin_prev_reg <= '0;
    else       pin_prev_reg <= pin_sync;
  end

  assign pin_rise = pin_sync & ~pin_prev_reg; // see [RULE_23]
  assign pin_fall = ~pin_sync & pin_prev_reg;

  // ==========================================================
  // clock source, divider and gate
  // oscillators are sampled, so they must run well below ref_clk / 2
  logic             int_tick;
  logic             div_legal;
  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] div_mask;
  logic             div_tick;
  logic             sel_tick;
  logic             counting;
  logic             count_tick;

  assign int_tick = (cfg.clock_source_select == SRC_FAST) ? pin_rise[0]
                  : (cfg.clock_source_select == SRC_SLOW) ? pin_rise[1]
                  : 1'b0;

  // reserved codes stop the count clock
  assign div_legal =
    (cfg.clock_source_select == SRC_FAST &&
     cfg.clock_divide_select <= DIV_FAST_MAX) ||
    (cfg.clock_source_select == SRC_SLOW &&
     cfg.clock_divide_select <= DIV_SLOW_MAX);        // see [RULE_03]

  always_ff @(posedge ref_clk) begin
    if (reset)         pre_reg <= '0;
    else if (int_tick) pre_reg <= pre_reg + 1'b1;
  end

  assign div_mask = (PRE_W'(1) << cfg.clock_divide_select) - 1'b1;
  assign div_tick = int_tick && div_legal &&
                    ((pre_reg & div_mask) == div_mask);  // see [RULE_03]

  assign sel_tick = (cfg.clock_source_select == SRC_EVENT) ? pin_rise[2]
                  : div_tick;                            // see [RULE_01]
  assign counting   = cfg.run && cfg.count_clock_gate_enable;
  assign count_tick = counting && sel_tick;              // see [RULE_04]

  // ==========================================================
  // compare
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cc_a_reg;
  logic [CNT_W-1:0] cc_b_reg;
  logic [CNT_W-1:0] buf_a_reg;
  logic [CNT_W-1:0] buf_b_reg;
  logic [CNT_W-1:0] eff_a;
  logic [CNT_W-1:0] eff_b;
  logic             hit_a;
  logic             hit_b;

  assign eff_a = cfg.compare_buffer_enable ? buf_a_reg : cc_a_reg;
  assign eff_b = cfg.compare_buffer_enable ? buf_b_reg : cc_b_reg;
  // see [RULE_06] [RULE_19]
  assign hit_a = count_tick && !cfg.reg_a_mode_select && cnt_reg == eff_a;
  assign hit_b = count_tick && !cfg.reg_b_mode_select && cnt_reg == eff_b;

  always_ff @(posedge ref_clk) begin
    if (reset)              cnt_reg <= CNT_RESET;
    else if (counter_clear) cnt_reg <= CNT_RESET;    // see [RULE_21]
    else if (hit_b)         cnt_reg <= CNT_RESET;    // see [RULE_08]
    else if (count_tick)    cnt_reg <= cnt_reg + 1'b1; // see [RULE_09]
  end

  // buffers follow the written values at each B match
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      buf_a_reg <= CNT_RESET;
      buf_b_reg <= CNT_RESET;
    end else if (hit_b) begin
      buf_a_reg <= cc_a_reg;                         // see [RULE_11]
      buf_b_reg <= cc_b_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      compare_a_event <= 1'b0;
      compare_b_event <= 1'b0;
    end else begin
      compare_a_event <= hit_a;                      // see [RULE_07]
      compare_b_event <= hit_b;                      // see [RULE_08]
    end
  end

  // ==========================================================
  // capture
  logic cap_a;
  logic cap_b;

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic rise,
                                    input logic fall);
    edge_hit = (sel[0] && rise) || (sel[1] && fall); // see [RULE_13]
  endfunction

  // see [RULE_14] [RULE_18]
  assign cap_a = cfg.reg_a_mode_select && counting &&
                 edge_hit(cfg.capture_a_edge_select, pin_rise[3], pin_fall[3]);
  assign cap_b = cfg.reg_b_mode_select && counting &&
                 edge_hit(cfg.capture_b_edge_select, pin_rise[4], pin_fall[4]);

  // capture beats a software write landing on the same edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cc_a_reg <= CNT_RESET;
      cc_b_reg <= CNT_RESET;
    end else begin
      if (cap_a)         cc_a_reg <= cnt_reg;        // see [RULE_14]
      else if (wr_a.we)  cc_a_reg <= wr_a.data;
      if (cap_b)         cc_b_reg <= cnt_reg;
      else if (wr_b.we)  cc_b_reg <= wr_b.data;
    end
  end

  // ==========================================================
  // flags and shared interrupt
  logic [FLG_W-1:0] flg_reg;
  logic [FLG_W-1:0] flg_set;

  always_comb begin
    flg_set            = '0;
    flg_set[FLG_CMP_A] = hit_a;
    flg_set[FLG_CMP_B] = hit_b;
    flg_set[FLG_CAP_A] = cap_a;
    flg_set[FLG_CAP_B] = cap_b;
    flg_set[FLG_OVW_A] = cap_a && flg_reg[FLG_CAP_A]; // see [RULE_15]
    flg_set[FLG_OVW_B] = cap_b && flg_reg[FLG_CAP_B];
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) flg_reg <= FLG_RESET;
    else       flg_reg <= (flg_reg & ~flag_clear) | flg_set;
  end

  assign irq_req     = |(flg_reg & irq_enable);      // see [RULE_22]
  assign flags       = flg_reg;
  assign count_value = cnt_reg;
  assign reg_a_value = cc_a_reg;
  assign reg_b_value = cc_b_reg;

  // ==========================================================
  // assertions
  property p_src_reserved;
    @(posedge ref_clk) disable iff (reset)
      cfg.clock_source_select == 2'h2 |-> !count_tick;
  endproperty
  a_src_reserved: assert property (p_src_reserved) // see [RULE_01]
    else $error("count tick from reserved source");
  property p_div_reserved;
    @(posedge ref_clk) disable iff (reset)
      (cfg.clock_divide_select == 4'hF ||
       (cfg.clock_source_select == SRC_SLOW &&
        cfg.clock_divide_select > DIV_SLOW_MAX)) |-> !div_tick;
  endproperty
  a_div_reserved: assert property (p_div_reserved) // see [RULE_03]
    else $error("divider ticks on reserved code");

  property p_gate;
    @(posedge ref_clk) disable iff (reset)
      !cfg.count_clock_gate_enable && !counter_clear |=> $stable(cnt_reg);
  endproperty
  a_gate: assert property (p_gate) // see [RULE_04]
    else $error("counter moved with gate closed");
  property p_cmp_a;
    @(posedge ref_clk) disable iff (reset)
      hit_a |=> compare_a_event && flg_reg[FLG_CMP_A];
  endproperty
  a_cmp_a: assert property (p_cmp_a) // see [RULE_07]
    else $error("compare A match not reported");
  property p_cmp_b;
    @(posedge ref_clk) disable iff (reset)
      count_tick && !cfg.reg_b_mode_select && cnt_reg == eff_b
      |=> compare_b_event && cnt_reg == 16'h0000 && flg_reg[FLG_CMP_B];
  endproperty
  a_cmp_b: assert property (p_cmp_b) // see [RULE_08]
    else $error("compare B did not clear counter");

  property p_buf;
    @(posedge ref_clk) disable iff (reset)
      hit_b |=> buf_a_reg == $past(cc_a_reg) && buf_b_reg == $past(cc_b_reg);
  endproperty
  a_buf: assert property (p_buf) // see [RULE_11]
    else $error("buffers not reloaded on compare B");
  property p_capture;
    @(posedge ref_clk) disable iff (reset)
      cap_a |=> cc_a_reg == $past(cnt_reg) && flg_reg[FLG_CAP_A];
  endproperty
  a_capture: assert property (p_capture) // see [RULE_14]
    else $error("capture A lost the count");

  property p_ovw;
    @(posedge ref_clk) disable iff (reset)
      cap_b && flg_reg[FLG_CAP_B] |=> flg_reg[FLG_OVW_B];
  endproperty
  a_ovw: assert property (p_ovw) // see [RULE_15]
    else $error("overwrite B not flagged");
  property p_no_cap;
    @(posedge ref_clk) disable iff (reset)
      !cfg.reg_a_mode_select && !wr_a.we |=> $stable(cc_a_reg);
  endproperty
  a_no_cap: assert property (p_no_cap) // see [RULE_18]
    else $error("capture in comparator mode");

  property p_no_cmp;
    @(posedge ref_clk) disable iff (reset)
      cfg.reg_a_mode_select && $past(cfg.reg_a_mode_select)
      |-> !compare_a_event;
  endproperty
  a_no_cmp: assert property (p_no_cmp) // see [RULE_19]
    else $error("compare event in capture mode");

  property p_irq;
    @(posedge ref_clk) disable iff (reset)
      hit_a && irq_enable[FLG_CMP_A] && !reset |=> irq_req;
  endproperty
  a_irq: assert property (p_irq) // see [RULE_22]
    else $error("enabled cause raised no request");

  c_cmp_b: cover property (@(posedge ref_clk) disable iff (reset)
    compare_b_event);
  c_cap_a: cover property (@(posedge ref_clk) disable iff (reset)
    cap_a);
  c_ovw_b: cover property (@(posedge ref_clk) disable iff (reset)
    flg_set[FLG_OVW_B]);
  c_event_clk: cover property (@(posedge ref_clk) disable iff (reset)
    count_tick && cfg.clock_source_select == SRC_EVENT);

endmodule

//--- sim/tcc_pins.sv
// pin-side model: oscillators, event clock and capture triggers
`timescale 1ns/10ps

// ==========================================================
module tcc_pins (
  input  wire logic ref_clk,  // timer clock
  output logic      fast_osc, // fast source pin
  output logic      slow_osc, // slow source pin
  output logic      evt,      // event clock pin
  output logic      trg_a,    // capture A trigger
  output logic      trg_b     // capture B trigger
);
  // 4 and 8 clock periods, offset so edges never meet ref_clk
  initial begin
    fast_osc = 1'b0;
    #12;
    forever #100 fast_osc = ~fast_osc;
  end
  initial begin
    slow_osc = 1'b0;
    #12;
    forever #200 slow_osc = ~slow_osc;
  end
  initial begin
    evt = 1'b0;
    trg_a = 1'b0;
    trg_b = 1'b0;
  end
  // three clocks per phase: the synchroniser needs two
  task automatic hold3();
    repeat (3) @(posedge ref_clk);
    #5;
  endtask
  task automatic evt_pulses(input int n);
    repeat (n) begin
      evt = 1'b1;
      hold3();
      evt = 1'b0;
      hold3();
    end
  endtask
  task automatic set_trg(input logic a, input logic b);
    trg_a = a;
    trg_b = b;
    hold3();
  endtask
endmodule

//--- sim/tcc_timer_tb.sv
// self-checking bench for the timer clock/compare/capture block
`timescale 1ns/10ps

// ==========================================================
module tcc_timer_tb;
  import tcc_pkg::*;
  logic        ref_clk;
  logic        reset;
  tcc_cfg_t    cfg;
  logic        counter_clear;
  tcc_wr_t     wr_a;
  tcc_wr_t     wr_b;
  logic [5:0]  flag_clear;
  logic [5:0]  irq_enable;
  logic        fast_osc, slow_osc, evt, trg_a, trg_b;
  logic [15:0] count_value, reg_a_value, reg_b_value;
  logic [5:0]  flags;
  logic        cmp_a, cmp_b, irq_req;
  int          errors = 0;
  int          checks_done = 0;
  int          n;

  tcc_timer dut (.ref_clk(ref_clk), .reset(reset), .cfg(cfg),
    .counter_clear(counter_clear), .wr_a(wr_a), .wr_b(wr_b),
    .flag_clear(flag_clear), .irq_enable(irq_enable),
    .fast_oscillator(fast_osc), .slow_oscillator(slow_osc),
    .event_clock_in(evt), .capture_a_trigger_in(trg_a),
    .capture_b_trigger_in(trg_b), .count_value(count_value),
    .reg_a_value(reg_a_value), .reg_b_value(reg_b_value),
    .flags(flags), .compare_a_event(cmp_a),
    .compare_b_event(cmp_b), .irq_req(irq_req));

  tcc_pins pins (.ref_clk(ref_clk), .fast_osc(fast_osc),
    .slow_osc(slow_osc), .evt(evt), .trg_a(trg_a), .trg_b(trg_b));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ========================================================
  // helpers
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #5;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // cycles until the next compare pulse (a_sel picks A)
  task automatic wait_ev(input logic a_sel, output int k);
    k = 0;
    do begin
      step(1);
      k++;
      if (k > 20000) begin
        errors++;
        summarize();
      end
    end while ((a_sel ? cmp_a : cmp_b) !== 1'b1);
  endtask
  // writes kept nine ref_clk cycles apart
  task automatic set_cmp(input logic [15:0] a, input logic [15:0] b);
    wr_a = '{1'b1, a};
    step(1);
    wr_a.we = 1'b0;
    step(8);
    wr_b = '{1'b1, b};
    step(1);
    wr_b.we = 1'b0;
  endtask
  task automatic clk_cfg(input logic [1:0] s, input logic [3:0] d);
    cfg.run = 1'b0;
    step(1);
    cfg.clock_source_select = s;
    cfg.clock_divide_select = d;
    cfg.count_clock_gate_enable = 1'b1;
    counter_clear = 1'b1;
    step(1);
    counter_clear = 1'b0;
    cfg.run = 1'b1;
  endtask

  // ========================================================
  // scenarios
  task automatic s_compare();
    set_cmp(16'h0001, 16'h0003);
    irq_enable = 6'h03;
    clk_cfg(SRC_FAST, 4'h0);
    wait_ev(1'b0, n);
    wait_ev(1'b0, n);
    chk(16'(n), 16'h0010);
    chk(count_value, 16'h0000);
    chk(16'(flags), 16'h0003);
    chk(16'(irq_req), 16'h0001);
    wait_ev(1'b1, n);
    chk(16'(n), 16'h0008);
    // enable kept one cycle past the match so the request can show
    step(1);
    flag_clear = 6'h3F;
    irq_enable = 6'h00;
    step(1);
    flag_clear = 6'h00;
    wait_ev(1'b0, n);
    chk(16'(irq_req), 16'h0000);
  endtask
  task automatic s_clocks();
    logic [5:0] sel [4] = '{6'h02, 6'h10, 6'h18, 6'h01};
    int per [4] = '{64, 32, 8192, 32};
    logic [5:0] bad [3] = '{6'h20, 6'h0F, 6'h19};
    for (int i = 0; i < 4; i++) begin
      clk_cfg(sel[i][5:4], sel[i][3:0]);
      wait_ev(1'b0, n);
      wait_ev(1'b0, n);
      chk(16'(n), 16'(per[i]));
    end
    for (int i = 0; i < 3; i++) begin
      clk_cfg(bad[i][5:4], bad[i][3:0]);
      step(300);
      chk(count_value, 16'h0000);
    end
  endtask
  task automatic s_buffer();
    cfg.compare_buffer_enable = 1'b1;
    clk_cfg(SRC_FAST, 4'h0);
    wait_ev(1'b0, n);
    wr_b = '{1'b1, 16'h0007};
    step(1);
    wr_b.we = 1'b0;
    wait_ev(1'b0, n);
    chk(16'(n), 16'h000F);
    wait_ev(1'b0, n);
    chk(16'(n), 16'h0020);
    cfg.compare_buffer_enable = 1'b0;
  endtask
  task automatic s_capture();
    int cnt;
    logic [15:0] exp_a;
    set_cmp(16'h0000, 16'hFFFF);
    cfg.reg_a_mode_select = 1'b1;
    cfg.capture_b_edge_select = 2'h3;
    clk_cfg(SRC_EVENT, 4'h0);
    flag_clear = 6'h3F;
    step(1);
    flag_clear = 6'h00;
    pins.evt_pulses(5);
    step(3);
    chk(count_value, 16'h0005);
    cnt = 5;
    exp_a = 16'h0000;
    for (int e = 0; e < 4; e++) begin
      cfg.capture_a_edge_select = 2'(e);
      pins.evt_pulses(1);
      cnt++;
      pins.set_trg(1'b1, 1'b1);
      step(2);
      if (e[0])
        exp_a = 16'(cnt);
      chk(reg_a_value, exp_a);
      chk(16'(flags[2]), 16'(e[0]));
      pins.evt_pulses(1);
      cnt++;
      pins.set_trg(1'b0, 1'b0);
      step(2);
      if (e[1])
        exp_a = 16'(cnt);
      chk(reg_a_value, exp_a);
      chk(16'(flags[4]), 16'(e == 3));
      chk(reg_b_value, 16'hFFFF);
      flag_clear = 6'h14;
      step(1);
      flag_clear = 6'h00;
    end
    // B as capture too: two edges with no clear between them
    cfg.reg_b_mode_select = 1'b1;
    pins.set_trg(1'b0, 1'b1);
    pins.set_trg(1'b0, 1'b0);
    step(2);
    chk(reg_b_value, 16'(cnt));
    chk(reg_b_value, 16'(cnt));
    chk(16'(flags[5:3]), 16'h0005);
    chk(16'(flags[0]), 16'h0000);
    counter_clear = 1'b1;
    step(1);
    counter_clear = 1'b0;
    chk(count_value, 16'h0000);
  endtask

  // ========================================================
  initial begin
    reset = 1'b1;
    cfg = '0;
    counter_clear = 1'b0;
    wr_a = '0;
    wr_b = '0;
    flag_clear = 6'h00;
    irq_enable = 6'h00;
    step(10);
    reset = 1'b0;
    step(3);
    cfg.run = 1'b1;
    step(40);
    chk(count_value, 16'h0000);
    chk(16'(flags), 16'h0000);
    s_compare();
    s_clocks();
    s_buffer();
    s_capture();
    summarize();
  end
endmodule
